// ### design/dxs_i2c_dac_io_expander_slave.sv
// Functional notes
// - split pin chooses four or eight channels
// - split high: drop upper port write nibble
// - split high: upper read nibble reads zero
// - write direction routes data port or channel
// - read direction samples port, sends master
// - channel code zero: single port transfer
// - codes one to four select channels 1-4
// - codes five to eight only split high
// - eight channels only with four-bit port
// - code all ones: continuous port writes
// - continuous writes end at start or stop
// - read: no channel byte, bytes until master nack
// - acknowledge every byte master sends once addressed
// - port floats after read until port write acked
// - port drives on write, samples on read
// - combined mode only while function pin high
// - respond only to matching seven-bit address
// - each channel holds eight-bit binary code
module dxs_i2c_dac_io_expander_slave #(
    parameter int ADDR_W = 12                      // ahb address width
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire logic              function_select_pin,
    input  wire logic              split_select_pin,
    input  wire logic              address_pin_0,
    input  wire logic              address_pin_1,
    input  wire logic [7:0]        port_i,
    output logic [7:0]             port_o,
    output logic [7:0]             port_oe,
    output logic [7:0][7:0]        analog_code
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration check: map needs nine address bits
    if (ADDR_W < 9) begin : g_bad_addr_w
        $error("ADDR_W must be at least 9");
    end

    dxs_pkg::dxs_regs_t r_reg;   // registered state
    dxs_pkg::dxs_regs_t r_next;  // next state

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        logic       scl_rise;     // scl edges and bus conditions
        logic       scl_fall;
        logic       start_c;
        logic       stop_c;
        logic       split;        // synchronised straps
        logic       func;
        logic [7:0] port_mask;
        logic [7:0] port_sample;
        logic       addr_match;
        logic       addr_ph;      // ahb address phase taken
        logic [7:0] rd_data;
        scl_rise    = r_reg.scl_sync[1] & ~r_reg.scl_d;
        scl_fall    = ~r_reg.scl_sync[1] & r_reg.scl_d;
        start_c     = r_reg.scl_sync[1] & r_reg.scl_d & r_reg.sda_d
                      & ~r_reg.sda_sync[1];
        stop_c      = r_reg.scl_sync[1] & r_reg.scl_d & ~r_reg.sda_d
                      & r_reg.sda_sync[1];
        func        = r_reg.cfg_s2[3];
        split       = r_reg.cfg_s2[2];
        port_mask   = split ? dxs_pkg::DXS_MASK_NARW
                            : dxs_pkg::DXS_MASK_WIDE;
        port_sample = r_reg.pin_s2 & port_mask;
        addr_match  = (r_reg.shreg[7:1] == {dxs_pkg::DXS_ADDR_FIXED,
                                            r_reg.cfg_s2[2:0]})
                      & func & r_reg.ctrl_en;
        addr_ph     = hsel & htrans[1] & hready;
        rd_data     = 8'h00;
        r_next      = r_reg;

        // synchronisers and edge history
        r_next.scl_sync = {r_reg.scl_sync[0], scl_i};
        r_next.sda_sync = {r_reg.sda_sync[0], sda_i};
        r_next.scl_d    = r_reg.scl_sync[1];
        r_next.sda_d    = r_reg.sda_sync[1];
        r_next.pin_s1   = port_i;
        r_next.pin_s2   = r_reg.pin_s1;
        r_next.cfg_s1   = {function_select_pin, split_select_pin,
                           address_pin_1, address_pin_0};
        r_next.cfg_s2   = r_reg.cfg_s1;

        ////////////////////////////////////////////////////////////////////
        // serial engine
        if (start_c) begin
            // start ends any sequence and opens a new one
            r_next.state  = dxs_pkg::DXS_ADDR;
            r_next.bitcnt = 4'h0;
            r_next.sda_oe = 1'b0;
            r_next.cont   = 1'b0;
        end else if (stop_c) begin
            r_next.state  = dxs_pkg::DXS_IDLE;
            r_next.sda_oe = 1'b0;
            r_next.cont   = 1'b0;
        end else begin
            case (r_reg.state)
                dxs_pkg::DXS_ADDR, dxs_pkg::DXS_CHAN,
                dxs_pkg::DXS_WDATA: begin
                    // shift in on rise, act on fall
                    if (scl_rise && r_reg.bitcnt < dxs_pkg::DXS_BIT_LAST)
                    begin
                        r_next.shreg  = {r_reg.shreg[6:0],
                                         r_reg.sda_sync[1]};
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end else if (scl_fall &&
                                 r_reg.bitcnt == dxs_pkg::DXS_BIT_LAST)
                    begin
                        // byte complete: decide and drive acknowledge
                        r_next.bitcnt = dxs_pkg::DXS_BIT_ACK;
                        r_next.sda_oe = 1'b1;
                        case (r_reg.state)
                            dxs_pkg::DXS_ADDR: begin
                                r_next.rw = r_reg.shreg[0];
                                if (!addr_match) begin
                                    // not ours: stay silent
                                    r_next.sda_oe = 1'b0;
                                    r_next.state  = dxs_pkg::DXS_IGNORE;
                                end else if (r_reg.shreg[0]) begin
                                    r_next.port_oe = 8'h00;
                                end
                            end
                            dxs_pkg::DXS_CHAN: begin
                                // upper nibble is ignored
                                r_next.code = r_reg.shreg[3:0];
                                r_next.done = 1'b0;
                                r_next.cont = (r_reg.shreg[3:0] ==
                                    dxs_pkg::DXS_CODE_CONT);
                            end
                            default: begin
                                // data byte, routed by the code
                                if (r_reg.cont || (!r_reg.done &&
                                    r_reg.code == dxs_pkg::DXS_CODE_PORT))
                                begin
                                    // port write, drive on acknowledge
                                    r_next.port_out = r_reg.shreg
                                        & port_mask;
                                    r_next.port_oe  = port_mask;
                                    r_next.done     = 1'b1;
                                end
                                for (int i = 0; i < 8; i++) begin
                                    if (!r_reg.done && !r_reg.cont &&
                                        r_reg.code == 4'(i + 1) &&
                                        (i < dxs_pkg::DXS_LOW_CHANS ||
                                         split)) begin
                                        r_next.analog[i] = r_reg.shreg;
                                        r_next.done      = 1'b1;
                                    end
                                end
                            end
                        endcase
                    end else if (scl_fall &&
                                 r_reg.bitcnt == dxs_pkg::DXS_BIT_ACK)
                    begin
                        // acknowledge over: release and move on
                        r_next.sda_oe = 1'b0;
                        r_next.bitcnt = 4'h0;
                        if (r_reg.state == dxs_pkg::DXS_ADDR) begin
                            if (r_reg.rw) begin
                                // read: no channel byte follows
                                r_next.state   = dxs_pkg::DXS_READ;
                                r_next.port_oe = 8'h00;
                                r_next.shreg   = port_sample;
                                r_next.sda_oe  = ~port_sample[7];
                            end else begin
                                r_next.state = dxs_pkg::DXS_CHAN;
                            end
                        end else begin
                            r_next.state = dxs_pkg::DXS_WDATA;
                        end
                    end
                end
                dxs_pkg::DXS_READ: begin
                    // bits go out after scl falls
                    if (scl_rise) begin
                        if (r_reg.bitcnt == dxs_pkg::DXS_BIT_LAST) begin
                            if (r_reg.sda_sync[1]) begin
                                // master declined: end of read
                                r_next.state = dxs_pkg::DXS_IGNORE;
                            end else begin
                                r_next.bitcnt = dxs_pkg::DXS_BIT_ACK;
                            end
                        end else begin
                            r_next.bitcnt = r_reg.bitcnt + 4'h1;
                        end
                    end else if (scl_fall) begin
                        if (r_reg.bitcnt == dxs_pkg::DXS_BIT_LAST) begin
                            // let the master acknowledge
                            r_next.sda_oe = 1'b0;
                        end else if (r_reg.bitcnt ==
                                     dxs_pkg::DXS_BIT_ACK) begin
                            // next byte, fresh port sample
                            r_next.shreg  = port_sample;
                            r_next.sda_oe = ~port_sample[7];
                            r_next.bitcnt = 4'h0;
                        end else begin
                            r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
                            r_next.sda_oe = ~r_reg.shreg[6];
                        end
                    end
                end
                dxs_pkg::DXS_IDLE, dxs_pkg::DXS_IGNORE: begin
                    // wait for a bus condition
                    r_next.sda_oe = 1'b0;
                end
                default: begin
                    r_next.state  = dxs_pkg::DXS_IDLE;
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // ahb-lite slave, no wait states, always okay
        r_next.hreadyout = 1'b1;
        if (hready) begin
            r_next.dph_valid = addr_ph;
            r_next.dph_write = hwrite;
            r_next.dph_word  = (hsize == dxs_pkg::DXS_HSIZE_WORD);
            r_next.dph_addr  = haddr[7:0];
        end
        // data phase write: only control is writable
        if (r_reg.dph_valid && r_reg.dph_write && r_reg.dph_word &&
            r_reg.dph_addr == dxs_pkg::DXS_REG_CTRL) begin
            r_next.ctrl_en = hwdata[dxs_pkg::DXS_CTRL_EN];
        end
        // read data prepared in the address phase
        if (addr_ph && !hwrite) begin
            r_next.hrdata = 32'h0000_0000;
            if (haddr[ADDR_W-1:8] == '0) begin
                case (haddr[7:0])
                    dxs_pkg::DXS_REG_CTRL: begin
                        r_next.hrdata[0] = r_reg.ctrl_en;
                    end
                    dxs_pkg::DXS_REG_STATUS: begin
                        rd_data = {r_reg.rw, split, func, r_reg.cont,
                                   |r_reg.port_oe, r_reg.state};
                        r_next.hrdata[7:0] = rd_data;
                    end
                    dxs_pkg::DXS_REG_PORT: begin
                        r_next.hrdata[15:0] = {port_sample,
                                               r_reg.port_out};
                    end
                    dxs_pkg::DXS_REG_AN_LO: begin
                        r_next.hrdata = r_reg.analog[3:0];
                    end
                    dxs_pkg::DXS_REG_AN_HI: begin
                        r_next.hrdata = r_reg.analog[7:4];
                    end
                    default: begin
                        r_next.hrdata = 32'h0000_0000;  // unmapped
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, constants only under reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg           <= '0;
            r_reg.scl_sync  <= 2'h3;  // idle bus reads high
            r_reg.sda_sync  <= 2'h3;
            r_reg.scl_d     <= 1'b1;
            r_reg.sda_d     <= 1'b1;
            r_reg.state     <= dxs_pkg::DXS_IDLE;
            r_reg.ctrl_en   <= dxs_pkg::DXS_CTRL_RST;
            r_reg.hreadyout <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register, hresp and sda_o tied off
    assign hreadyout   = r_reg.hreadyout;
    assign hresp       = 1'b0;            // always okay
    assign hrdata      = r_reg.hrdata;
    assign sda_o       = 1'b0;            // open drain, only pulls low
    assign sda_oe      = r_reg.sda_oe;
    assign port_o      = r_reg.port_out;
    assign port_oe     = r_reg.port_oe;
    assign analog_code = r_reg.analog;

endmodule : dxs_i2c_dac_io_expander_slave

// ### design/dxs_pkg.sv
package dxs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // serial side constants
    localparam logic [3:0] DXS_ADDR_FIXED = 4'h9;  // upper four address bits
    localparam logic [3:0] DXS_CODE_PORT  = 4'h0;  // single port transfer
    localparam logic [3:0] DXS_CODE_CONT  = 4'hF;  // continuous port writes
    localparam logic [3:0] DXS_BIT_LAST   = 4'h8;  // eight bits shifted
    localparam logic [3:0] DXS_BIT_ACK    = 4'h9;  // acknowledge slot
    localparam int         DXS_LOW_CHANS  = 4;     // channels in both splits
    localparam logic [7:0] DXS_MASK_WIDE  = 8'hFF; // eight-bit port
    localparam logic [7:0] DXS_MASK_NARW  = 8'h0F; // four-bit port

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0] DXS_REG_CTRL   = 8'h00; // bit0 serial enable
    localparam logic [7:0] DXS_REG_STATUS = 8'h04; // engine state, read only
    localparam logic [7:0] DXS_REG_PORT   = 8'h08; // port out / port in
    localparam logic [7:0] DXS_REG_AN_LO  = 8'h0C; // codes of channels 1-4
    localparam logic [7:0] DXS_REG_AN_HI  = 8'h10; // codes of channels 5-8
    localparam int         DXS_CTRL_EN    = 0;     // enable bit position
    localparam logic       DXS_CTRL_RST   = 1'h1;  // enabled after reset
    localparam logic [2:0] DXS_HSIZE_WORD = 3'h2;  // only word writes

    ////////////////////////////////////////////////////////////////////////
    // serial engine states
    typedef enum logic [2:0] {
        DXS_IDLE,    // waiting for a start
        DXS_ADDR,    // receiving the address byte
        DXS_CHAN,    // receiving the channel byte
        DXS_WDATA,   // receiving data bytes
        DXS_READ,    // sending port bytes
        DXS_IGNORE   // not addressed, wait for start or stop
    } dxs_state_t;

    // whole state of the block
    typedef struct packed {
        logic [1:0]      scl_sync;  // [0] first flop, [1] second
        logic [1:0]      sda_sync;
        logic            scl_d;     // delayed copy for edges
        logic            sda_d;
        logic [7:0]      pin_s1;    // port input synchroniser
        logic [7:0]      pin_s2;
        logic [3:0]      cfg_s1;    // strap pin synchroniser
        logic [3:0]      cfg_s2;
        dxs_state_t      state;
        logic [3:0]      bitcnt;    // bits of current byte
        logic [7:0]      shreg;     // serial shift register
        logic            rw;        // direction bit of address
        logic [3:0]      code;      // low nibble of channel byte
        logic            done;      // single transfer used up
        logic            cont;      // continuous port writes
        logic            sda_oe;    // pulls sda low
        logic [7:0]      port_out;
        logic [7:0]      port_oe;
        logic [7:0][7:0] analog;    // channel codes
        logic            ctrl_en;
        logic            dph_valid; // ahb data phase pending
        logic            dph_write;
        logic            dph_word;
        logic [7:0]      dph_addr;
        logic [31:0]     hrdata;
        logic            hreadyout;
    } dxs_regs_t;

endpackage : dxs_pkg

// ### tb/dxs_chk_sva.sv
module dxs_chk_sva (
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic            scl_i,
    input wire logic            sda_o,
    input wire logic            sda_oe,
    input wire logic            function_select_pin,
    input wire logic            split_select_pin,
    input wire logic [7:0]      port_o,
    input wire logic [7:0]      port_oe,
    input wire logic [7:0][7:0] analog_code
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////
    // one clock domain for all checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////
    bus_okay_a: assert property (hresp == 1'h0 && hreadyout == 1'h1)
        else $error("bus answer not okay or not ready");
    sda_edge_a: assert property ($changed(sda_oe) |-> !scl_i && !sda_o)
        else $error("data line moved while clock high");
    mask_set_a: assert property (port_oe inside {8'h00, 8'h0F, 8'hFF})
        else $error("port enables not a legal width");
    narrow_out_a: assert property (
        split_select_pin && $changed(port_o) |-> port_o[7:4] == 4'h0)
        else $error("upper port nibble written in narrow split");
    high_chan_a: assert property ($changed(analog_code[7:4]) |-> split_select_pin)
        else $error("channels five to eight changed in wide split");
    chan_ack_a: assert property (
        $changed(analog_code) |-> sda_oe || $past(sda_oe))
        else $error("channel code changed away from an ack");
    port_ack_a: assert property (
        $changed(port_o) || $rose(port_oe[0]) |-> sda_oe || $past(sda_oe))
        else $error("port driven away from an ack");
    turn_read_a: assert property (
        $fell(port_oe[0]) |-> sda_oe || $past(sda_oe))
        else $error("port released away from an address ack");
    mode_off_a: assert property ((!function_select_pin) [*8] |-> !sda_oe)
        else $error("ack given with function pin low");
    // main scenarios reached
    high_chan_c: cover property ($changed(analog_code[7:4]));
    port_read_c: cover property ($fell(port_oe[0]));
    wide_port_c: cover property ($rose(port_oe[7]));
endmodule : dxs_chk_sva

// ### tb/dxs_i2c_master.sv
module dxs_i2c_master (
    input  wire logic hclk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////
    // bus idle at time zero, pull-up holds both lines high
    initial begin
        scl = 1'h1;
        sda = 1'h1;
    end
    // waits n edges, every change lands right after an edge
    task automatic tk(input int n);
        repeat (n) @(posedge hclk);
    endtask : tk
    // start (a=1, b=0) or stop (a=0, b=1), data moves with clock high
    task automatic cond(input logic a, input logic b);
        tk(1);
        sda <= a;
        tk(4);
        scl <= 1'h1;
        tk(4);
        sda <= b;
        tk(4);
        scl <= b;
    endtask : cond
    // nine bits msb first, clock low five cycles and high three
    // q keeps the line level seen at the end of each high phase
    task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            tk(1);
            sda <= d[i];
            tk(4);
            scl <= 1'h1;
            tk(3);
            q[i] = sda_in;
            scl <= 1'h0;
        end
    endtask : byte_io
endmodule : dxs_i2c_master

// ### tb/dxs_i2c_dac_io_expander_slave_tb_top.sv
module dxs_i2c_dac_io_expander_slave_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0]     haddr;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic [31:0]     hwdata, hrdata, rd;
    logic            scl, sda_m, sda_o, sda_oe, sda_w; // sda_w: line level
    logic            fsel, split, a1, a0;              // strap pins
    logic [7:0]      port_i, port_o, port_oe, ext;     // ext: far logic
    logic [7:0][7:0] an;
    logic [8:0]      q;                                // byte and ack
    logic [7:0]      cont_d [3] = '{8'h11, 8'h22, 8'h33};
    int              failures = 0;
    int              check_count = 0;
    // open drain line with pull-up; pins show own drive, else far logic
    assign sda_w  = sda_m & ~(sda_oe & ~sda_o);
    assign port_i = (port_o & port_oe) | (ext & ~port_oe);
    always #5 hclk = ~hclk;
    dxs_i2c_master m (.hclk(hclk), .sda_in(sda_w), .scl(scl), .sda(sda_m));
    dxs_i2c_dac_io_expander_slave dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .function_select_pin(fsel),
        .split_select_pin(split), .address_pin_0(a0), .address_pin_1(a1),
        .port_i(port_i), .port_o(port_o), .port_oe(port_oe),
        .analog_code(an));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one single word transfer, each phase held until hready is seen
    task automatic ahb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        {hsel, haddr, htrans, hwrite} <= {1'h1, a, 2'h2, w};
        hsize <= dxs_pkg::DXS_HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        {hsel, htrans, hwdata} <= {1'h0, 2'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        ahb(1'h0, a, 32'h0000_0000);
        chk("register", rd, e);
    endtask : rchk
    function automatic logic [7:0] sla(input logic rw);
        return {dxs_pkg::DXS_ADDR_FIXED, split, a1, a0, rw};
    endfunction : sla
    task automatic send(input logic [7:0] b, input logic a);
        m.byte_io({b, 1'h1}, q);
        chk("ack", q[0], a == 1'h0);
    endtask : send
    task automatic dev_wr(input logic [7:0] c, d);
        m.cond(1'h1, 1'h0);
        send(sla(1'h0), 1'h1);
        send(c, 1'h1);
        send(d, 1'h1);
        m.cond(1'h0, 1'h1);
    endtask : dev_wr
    // straps {function, split, addr1, addr0}, settled before use
    task automatic strap(input logic [3:0] v);
        {fsel, split, a1, a0} <= v;
        repeat (6) @(posedge hclk);
    endtask : strap
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    // watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        {hclk, hresetn} = 2'h0;
        {hsel, hwrite, haddr, htrans, hsize, hwdata} = 51'h0;
        {fsel, split, a1, a0, ext} = 12'h800;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        rchk(dxs_pkg::DXS_REG_CTRL, 32'h0000_0001);
        rchk(12'h020, 32'h0000_0000);
        rchk(dxs_pkg::DXS_REG_STATUS, 32'h0000_0020);
        rchk(dxs_pkg::DXS_REG_AN_LO, 32'h0000_0000);
        chk("float", port_oe, 32'h0000_0000);
        $display("test reset done");
        // single port write, the extra byte is acked but dropped
        m.cond(1'h1, 1'h0);
        send(sla(1'h0), 1'h1);
        send(8'h50, 1'h1);
        send(8'hA5, 1'h1);
        send(8'h3C, 1'h1);
        m.cond(1'h0, 1'h1);
        chk("wide oe", port_oe, 32'h0000_00FF);
        rchk(dxs_pkg::DXS_REG_PORT, 32'h0000_A5A5);
        // codes one to nine in the wide port split, junk upper nibble
        for (int n = 1; n <= 9; n++)
            dev_wr({4'hC, 4'(n)}, 8'(16 + n));
        rchk(dxs_pkg::DXS_REG_AN_LO, 32'h1413_1211);
        rchk(dxs_pkg::DXS_REG_AN_HI, 32'h0000_0000);
        chk("port kept", port_o, 32'h0000_00A5);
        $display("test wide split done");
        strap(4'hE);
        for (int n = 1; n <= 8; n++)
            dev_wr(8'(n), 8'(48 + n));
        rchk(dxs_pkg::DXS_REG_AN_LO, 32'h3433_3231);
        rchk(dxs_pkg::DXS_REG_AN_HI, 32'h3837_3635);
        m.cond(1'h1, 1'h0);
        send({dxs_pkg::DXS_ADDR_FIXED, 4'h8}, 1'h0);
        m.cond(1'h0, 1'h1);
        dev_wr(8'h00, 8'hF6);
        chk("narrow out", port_o, 32'h0000_0006);
        chk("narrow oe", port_oe, 32'h0000_000F);
        ext <= 8'hC3;
        m.cond(1'h1, 1'h0);
        send(sla(1'h1), 1'h1);
        m.byte_io(9'h1FE, q);
        m.byte_io(9'h1FF, q);
        m.cond(1'h0, 1'h1);
        chk("narrow read", q[8:1], 32'h0000_0003);
        chk("read oe", port_oe, 32'h0000_0000);
        $display("test narrow split done");
        // read two bytes while the far logic changes its value
        strap(4'h8);
        ext <= 8'h5A;
        m.cond(1'h1, 1'h0);
        send(sla(1'h1), 1'h1);
        fork
            m.byte_io(9'h1FE, q);
            #200 ext <= 8'h96;
        join
        chk("read one", q[8:1], 32'h0000_005A);
        m.byte_io(9'h1FF, q);
        m.cond(1'h0, 1'h1);
        chk("read two", q[8:1], 32'h0000_0096);
        dev_wr(8'h01, 8'h77);
        chk("still float", port_oe, 32'h0000_0000);
        $display("test read done");
        // continuous writes, ended by a repeated start
        m.cond(1'h1, 1'h0);
        send(sla(1'h0), 1'h1);
        send(8'h6F, 1'h1);
        foreach (cont_d[i]) begin
            send(cont_d[i], 1'h1);
            chk("cont out", port_o, cont_d[i]);
        end
        chk("oe back", port_oe, 32'h0000_00FF);
        m.cond(1'h1, 1'h0);
        send(sla(1'h0), 1'h1);
        send(8'h02, 1'h1);
        send(8'h6B, 1'h1);
        m.cond(1'h0, 1'h1);
        chk("cont end", port_o, 32'h0000_0033);
        chk("chan two", an[1], 32'h0000_006B);
        $display("test continuous done");
        // refused while the function pin is low or serial is disabled
        strap(4'h0);
        m.cond(1'h1, 1'h0);
        send(sla(1'h0), 1'h0);
        m.cond(1'h0, 1'h1);
        strap(4'h8);
        ahb(1'h1, dxs_pkg::DXS_REG_CTRL, 32'h0000_0000);
        m.cond(1'h1, 1'h0);
        send(sla(1'h0), 1'h0);
        m.cond(1'h0, 1'h1);
        ahb(1'h1, dxs_pkg::DXS_REG_CTRL, 32'h0000_0001);
        dev_wr(8'h04, 8'hFE);
        chk("chan four", an[3], 32'h0000_00FE);
        $display("test refusal done");
        wrap_up();
    end
endmodule : dxs_i2c_dac_io_expander_slave_tb_top

bind dxs_i2c_dac_io_expander_slave dxs_chk_sva u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .function_select_pin(function_select_pin),
    .split_select_pin(split_select_pin), .port_o(port_o),
    .port_oe(port_oe), .analog_code(analog_code));
